// File: dv/dps_host_model.sv
// Host side of the decoded register bus: write and read tasks.
// Drives at the falling edge; expected read data goes into exp_q.
`timescale 1ns/1ps
`default_nettype none

module dps_host_model (
  input wire logic sys_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata
);
  logic [15:0] exp_q [$];

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end

  // Launch words are only sent after setup writes by the caller
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
  endtask : rd
endmodule : dps_host_model
`default_nettype wire

// File: dv/dps_sequencer_checker.sv
// Concurrent checks on the ports of the default power sequence engine.
// Assumes TICK_CYCLES = 4, as the bench instantiates it.
`timescale 1ns/1ps
`default_nettype none

module dps_sequencer_checker (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic in1_stage_on,
  input wire logic in2_stage_on,
  input wire logic charge_pump_on,
  input wire logic hp_left_output_stage,
  input wire logic hp_right_output_stage,
  input wire logic hp_left_unshort,
  input wire logic hp_right_unshort,
  input wire logic input_pair1_midrail_tie,
  input wire logic input_pair2_midrail_tie,
  input wire logic seq_busy,
  input wire logic [4:0] seq_index
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // Assertions
  // ==========================================================
  pu_launch_a: assert property (reg_wr && reg_addr == 8'h49 && reg_wdata == 16'h0100 |=>
    seq_busy && seq_index == 5'h00) else $error("start-up launch not taken");
  pd_launch_a: assert property (reg_wr && reg_addr == 8'h49 && reg_wdata == 16'h0110 |=>
    seq_busy && seq_index == 5'h10) else $error("shut-down launch not taken");
  tie_one_a: assert property (in1_stage_on |=> !input_pair1_midrail_tie)
    else $error("pair 1 tied while stage on");
  tie_two_a: assert property (in2_stage_on |=> !input_pair2_midrail_tie)
    else $error("pair 2 tied while stage on");
  pump_step_a: assert property ($rose(seq_busy) && seq_index == 5'h00 |=> charge_pump_on)
    else $error("charge pump not set by first step");
  first_hold_a: assert property ($rose(seq_busy) && seq_index == 5'h00 |->
    ##288 seq_index == 5'h01) else $error("first step length wrong");
  pd_length_a: assert property ($rose(seq_busy) && seq_index == 5'h10 |->
    ##179 seq_busy ##1 !seq_busy) else $error("shut-down length wrong");
  step_order_a: assert property (seq_busy && $past(seq_busy) && seq_index != $past(seq_index)
    |-> seq_index == $past(seq_index) + 5'h01) else $error("index not ascending");
  pd_clear_a: assert property ($rose(seq_busy) && seq_index == 5'h10 |=> !hp_left_output_stage
    && !hp_right_output_stage && !hp_left_unshort && !hp_right_unshort)
    else $error("outputs not cleared by step 16");

  // ==========================================================
  // Coverage
  // ==========================================================
  pu_run_c: cover property ($rose(seq_busy) && seq_index == 5'h00);
  pd_run_c: cover property ($rose(seq_busy) && seq_index == 5'h10);
  tie_c: cover property ($fell(input_pair1_midrail_tie));
endmodule : dps_sequencer_checker

bind dps_sequencer dps_sequencer_checker i_chk (
  .sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .in1_stage_on(in1_stage_on), .in2_stage_on(in2_stage_on),
  .charge_pump_on(charge_pump_on), .hp_left_output_stage(hp_left_output_stage),
  .hp_right_output_stage(hp_right_output_stage), .hp_left_unshort(hp_left_unshort),
  .hp_right_unshort(hp_right_unshort), .input_pair1_midrail_tie(input_pair1_midrail_tie),
  .input_pair2_midrail_tie(input_pair2_midrail_tie), .seq_busy(seq_busy),
  .seq_index(seq_index));
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the default power sequence engine.
// Uses TICK_CYCLES = 4 so a full start-up runs in 2708 cycles.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int TICK = 4;
  logic sys_clk, reset, in1_stage_on, in2_stage_on;
  logic reg_wr, reg_rd, pend;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v01, v4c, v54, v60, v16;
  logic charge_pump_on, hp_li, hp_ri, hp_ld, hp_rd, hp_lo, hp_ro, hp_lu, hp_ru;
  logic s0_on, s1_on, s0_k, s1_k, spk_on, mid_on, tie1, tie2, seq_busy;
  logic [4:0] seq_index;
  int error_cnt, total_checks, cyc, n;

  dps_host_model i_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  dps_sequencer #(.TICK_CYCLES(TICK)) i_dut (.sys_clk(sys_clk), .reset(reset),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .in1_stage_on(in1_stage_on), .in2_stage_on(in2_stage_on),
    .charge_pump_on(charge_pump_on), .hp_left_input_stage_on(hp_li),
    .hp_right_input_stage_on(hp_ri), .hp_left_delay_stage(hp_ld),
    .hp_right_delay_stage(hp_rd), .hp_left_output_stage(hp_lo),
    .hp_right_output_stage(hp_ro), .hp_left_unshort(hp_lu), .hp_right_unshort(hp_ru),
    .offset_servo_ch0_on(s0_on), .offset_servo_ch1_on(s1_on),
    .offset_servo_ch0_kick(s0_k), .offset_servo_ch1_kick(s1_k),
    .speaker_driver_on(spk_on), .midrail_buffer_on(mid_on),
    .input_pair1_midrail_tie(tie1), .input_pair2_midrail_tie(tie2),
    .seq_busy(seq_busy), .seq_index(seq_index));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Checking
  // ==========================================================
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  always @(posedge sys_clk) pend <= reg_rd;
  always @(negedge sys_clk) begin
    if (pend === 1'b1) chk("reg_rdata", i_host.exp_q.pop_front(), reg_rdata);
  end

  function automatic logic [15:0] put(input logic [15:0] o, input int st, input int w,
      input logic [7:0] d);
    logic [15:0] m;
    m = ((16'h0001 << w) - 16'h0001) << st;
    return (o & ~m) | ((16'(d) << st) & m);
  endfunction : put

  task automatic run(input logic [15:0] cmd, input int units);
    i_host.wr(8'h49, cmd);
    i_host.rd(8'h49, cmd);
    n = 2;
    while (seq_busy === 1'b1 && n < 4000) begin
      n++;
      @(negedge sys_clk);
    end
    chk("busy cycles", 16'(units * TICK), 16'(n));
  endtask : run

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    reset = 1'b1;
    in1_stage_on = 1'b0;
    in2_stage_on = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    void'($urandom(38798));
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    chk("midrail_buffer_on", 16'h0001, 16'(mid_on));
    chk("ties", 16'h0003, {14'h0, tie2, tie1});
    i_host.rd(8'h16, 16'h0001);
    i_host.rd(8'h17, 16'h0001);
    i_host.rd(8'h39, 16'h0008);
    i_host.rd(8'h02, 16'h0000);
    i_host.wr(8'h39, 16'h0000);
    chk("midrail_buffer_on off", 16'h0000, 16'(mid_on));
    i_host.wr(8'hFF, 16'hFFFF);
    i_host.wr(8'h49, 16'h0111);
    chk("seq_busy bad launch", 16'h0000, 16'(seq_busy));
    for (int i = 0; i < 6; i++) begin
      v16 = 16'($urandom);
      i_host.wr((i % 2) ? 8'h17 : 8'h16, v16);
      in1_stage_on = 1'($urandom);
      in2_stage_on = 1'($urandom);
      repeat (2) @(negedge sys_clk);
      if (i % 2) chk("tie2", 16'(v16[0] & ~in2_stage_on), 16'(tie2));
      else chk("tie1", 16'(v16[0] & ~in1_stage_on), 16'(tie1));
    end
    v01 = 16'($urandom);
    v4c = 16'($urandom) & 16'h7FFF;
    v54 = 16'($urandom);
    v60 = 16'($urandom);
    i_host.wr(8'h01, v01);
    i_host.wr(8'h4C, v4c);
    i_host.wr(8'h54, v54);
    i_host.wr(8'h60, v60);
    run(16'h0100, 677);
    v4c = put(v4c, 15, 1, 8'h01);
    v01 = put(v01, 7, 3, 8'h07);
    v60 = put(put(v60, 1, 5, 8'h11), 2, 6, 8'h3B);
    v54 = put(v54, 0, 7, 8'h33);
    i_host.rd(8'h4C, v4c);
    i_host.rd(8'h01, v01);
    i_host.rd(8'h60, v60);
    i_host.rd(8'h54, v54);
    chk("hp outputs", 16'h003F, {10'h0, hp_li, hp_ri, hp_lo, hp_ro, hp_lu, hp_ru});
    chk("servo", 16'h000F, {12'h0, s0_on, s1_on, s0_k, s1_k});
    chk("delay stages", 16'h0003, {14'h0, hp_ld, hp_rd});
    chk("seq_index", 16'h0007, 16'(seq_index));
    run(16'h0110, 45);
    v60 = put(v60, 1, 7, 8'h00);
    v54 = put(v54, 0, 2, 8'h00);
    v01 = put(put(v01, 8, 2, 8'h00), 12, 2, 8'h00);
    v4c = put(v4c, 15, 1, 8'h00);
    i_host.rd(8'h60, v60);
    i_host.rd(8'h54, v54);
    i_host.rd(8'h01, v01);
    i_host.rd(8'h4C, v4c);
    chk("drivers off", 16'h0000, {4'h0, charge_pump_on, spk_on, hp_ld, hp_rd,
      hp_li, hp_ri, s0_on, s1_on, hp_lo, hp_ro, hp_lu, hp_ru});
    chk("seq_index", 16'h0014, 16'(seq_index));
    repeat (3) @(negedge sys_clk);
    stop_test();
  end
endmodule : tb
`default_nettype wire

// File: hw/dps_pkg.sv
// Constants shared by the default power sequence logic: register map,
// field positions, reset values, launch commands and step timing.
// Assumes a 200 MHz system clock.
package dps_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] ADDR_PWR_MGMT_ONE = 8'h01;
  localparam logic [7:0] ADDR_IN1_LINE = 8'h16;
  localparam logic [7:0] ADDR_IN2_LINE = 8'h17;
  localparam logic [7:0] ADDR_ANTIPOP = 8'h39;
  localparam logic [7:0] ADDR_SEQ_CTRL = 8'h49;
  localparam logic [7:0] ADDR_CHARGE_PUMP = 8'h4C;
  localparam logic [7:0] ADDR_OFFSET_SERVO = 8'h54;
  localparam logic [7:0] ADDR_HP_ANALOGUE = 8'h60;
  localparam logic [7:0] ADDR_DUMMY = 8'hFF;

  localparam int NUM_SLOTS = 7;
  localparam logic [2:0] SLOT_PWR = 3'h0;
  localparam logic [2:0] SLOT_IN1 = 3'h1;
  localparam logic [2:0] SLOT_IN2 = 3'h2;
  localparam logic [2:0] SLOT_ANTIPOP = 3'h3;
  localparam logic [2:0] SLOT_CP = 3'h4;
  localparam logic [2:0] SLOT_SERVO = 3'h5;
  localparam logic [2:0] SLOT_HP = 3'h6;

  localparam logic [7:0] SLOT_ADDR [NUM_SLOTS] = '{
    ADDR_PWR_MGMT_ONE, ADDR_IN1_LINE, ADDR_IN2_LINE, ADDR_ANTIPOP,
    ADDR_CHARGE_PUMP, ADDR_OFFSET_SERVO, ADDR_HP_ANALOGUE};
  localparam logic [15:0] SLOT_RESET [NUM_SLOTS] = '{
    16'h0000, 16'h0001, 16'h0001, 16'h0008, 16'h0000, 16'h0000, 16'h0000};

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int BIT_HP_RIGHT_IN = 8;
  localparam int BIT_HP_LEFT_IN = 9;
  localparam int BIT_SPEAKER_ON = 12;
  localparam int BIT_CLAMP = 0;
  localparam int BIT_MIDRAIL_BUF = 3;
  localparam int BIT_CHARGE_PUMP = 15;
  localparam int BIT_SERVO_CH0 = 0;
  localparam int BIT_SERVO_CH1 = 1;
  localparam int BIT_KICK_CH0 = 4;
  localparam int BIT_KICK_CH1 = 5;
  localparam int BIT_HP_RIGHT_DLY = 1;
  localparam int BIT_HP_RIGHT_OUTP = 2;
  localparam int BIT_HP_RIGHT_UNSHORT = 3;
  localparam int BIT_HP_LEFT_DLY = 5;
  localparam int BIT_HP_LEFT_OUTP = 6;
  localparam int BIT_HP_LEFT_UNSHORT = 7;

  // ==========================================================
  // Launch commands
  // ==========================================================
  localparam logic [15:0] CMD_HP_STARTUP = 16'h0100;
  localparam logic [15:0] CMD_GENERIC_SHUTDOWN = 16'h0110;
  localparam logic [4:0] IDX_HP_STARTUP = 5'h00;
  localparam logic [4:0] IDX_GENERIC_SHUTDOWN = 5'h10;

  // ==========================================================
  // Step timing
  // ==========================================================
  localparam int SYS_CLK_MHZ = 200;
  localparam int STEP_UNIT_NS = 62500;
  localparam int STEP_UNIT_CYC = STEP_UNIT_NS * SYS_CLK_MHZ / 1000;
  localparam logic [15:0] STEP_BASE_UNITS = 16'h0008;

  typedef enum logic [1:0] {
    DPS_IDLE = 2'b00,
    DPS_WRITE = 2'b01,
    DPS_WAIT = 2'b10
  } dps_state_t;

endpackage : dps_pkg

// File: hw/dps_sequencer.sv
// Default power sequence engine with the control registers it writes.
// Host register accesses arrive already decoded from the two-wire
// control interface as one-cycle read and write strobes on sys_clk.
//
// Summary of operation
// - Writing 0100h to register 49h starts the sequencer at index 0.
// - The full headphone start-up list runs for about 42.3 ms.
// - Step 0 sets bit 15 of 4Ch, delay code 6h.
// - Step 1 writes 07h into three bits from bit 7 of 01h.
// - Step 2 writes 11h into five bits from bit 1 of 60h.
// - Step 3 writes 33h into seven bits from bit 0 of 54h, delay 9h.
// - Steps 4 to 6 are dummy writes to FFh; step 4 delay 5h.
// - Step 7 writes 3Bh into six bits from bit 2 of 60h, then stops.
// - Writing 0110h to register 49h starts the sequencer at index 16.
// - The generic shut-down list runs for about 2.8 ms.
// - Step 16 clears seven bits from bit 1 of 60h.
// - Step 17 clears two bits from bit 0 of 54h.
// - Step 18 clears two bits from bit 8 of 01h.
// - Step 19 clears bit 15 of 4Ch.
// - Step 20 clears two bits from bit 12 of 01h, then stops.
// - An input pair ties to mid-rail while clamped and its stage is off.
// - Bit 0 of 16h clamps input pair 1, reset value 1.
// - Bit 0 of 17h clamps input pair 2, reset value 1.
// - Bit 3 of 39h enables the mid-rail buffer, reset value 1.
// - Each step lasts 62.5 us times (2 to the delay code plus 8).
// - Width codes 0 to 7 mean 1 to 8 bits; higher data bits ignored.
// - A step with the end flag halts after its write and delay.
`timescale 1ns/1ps
`default_nettype none

module dps_sequencer #(
  parameter int unsigned TICK_CYCLES = dps_pkg::STEP_UNIT_CYC,
  parameter int PRESCALE_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic in1_stage_on,
  input wire logic in2_stage_on,
  output logic charge_pump_on,
  output logic hp_left_input_stage_on,
  output logic hp_right_input_stage_on,
  output logic hp_left_delay_stage,
  output logic hp_right_delay_stage,
  output logic hp_left_output_stage,
  output logic hp_right_output_stage,
  output logic hp_left_unshort,
  output logic hp_right_unshort,
  output logic offset_servo_ch0_on,
  output logic offset_servo_ch1_on,
  output logic offset_servo_ch0_kick,
  output logic offset_servo_ch1_kick,
  output logic speaker_driver_on,
  output logic midrail_buffer_on,
  output logic input_pair1_midrail_tie,
  output logic input_pair2_midrail_tie,
  output logic seq_busy,
  output logic [4:0] seq_index
);

  // ==========================================================
  // Helper functions
  // ==========================================================
  // Returns {hit, slot} for a control register address
  function automatic logic [3:0] slot_of(input logic [7:0] addr);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 0; i < dps_pkg::NUM_SLOTS; i++) begin
      if (addr == dps_pkg::SLOT_ADDR[i]) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction : slot_of

  // Replaces one field of a register, keeping every other bit
  function automatic logic [15:0] field_merge(
    input logic [15:0] old_val,
    input logic [3:0] start,
    input logic [2:0] width,
    input logic [7:0] data
  );
    logic [15:0] mask;
    logic [15:0] val;
    mask = (16'h00FF >> (3'h7 - width)) << start;
    val = ({8'h00, data} << start) & mask;
    return (old_val & ~mask) | val;
  endfunction : field_merge

  // ==========================================================
  // Step table
  // ==========================================================
  logic [7:0] rom_addr;
  logic [2:0] rom_width;
  logic [3:0] rom_start;
  logic [7:0] rom_data;
  logic [3:0] rom_delay;
  logic rom_end;

  dps_step_rom u_rom (
    .index(seq_index),
    .step_addr(rom_addr),
    .step_field_width(rom_width),
    .step_start(rom_start),
    .step_data(rom_data),
    .step_delay_code(rom_delay),
    .step_end_flag(rom_end)
  );

  // ==========================================================
  // Host decode
  // ==========================================================
  logic [3:0] host_slot;
  logic [3:0] seq_slot;
  logic host_seq_wr;
  logic launch;
  logic [4:0] launch_index;

  assign host_slot = slot_of(reg_addr);
  assign seq_slot = slot_of(rom_addr);
  assign host_seq_wr = reg_wr && (reg_addr == dps_pkg::ADDR_SEQ_CTRL);

  always_comb begin
    launch = 1'b0;
    launch_index = dps_pkg::IDX_HP_STARTUP;
    if (host_seq_wr && reg_wdata == dps_pkg::CMD_HP_STARTUP) begin
      launch = 1'b1;
      launch_index = dps_pkg::IDX_HP_STARTUP;
    end else if (host_seq_wr && reg_wdata == dps_pkg::CMD_GENERIC_SHUTDOWN) begin
      launch = 1'b1;
      launch_index = dps_pkg::IDX_GENERIC_SHUTDOWN;
    end
  end

  // ==========================================================
  // Sequencer state
  // ==========================================================
  dps_pkg::dps_state_t state;
  logic [PRESCALE_W-1:0] prescale;
  logic [15:0] unit_count;
  logic [15:0] step_units;
  logic unit_tick;
  logic step_done;
  logic seq_apply;
  logic [15:0] seq_cmd;

  // Whole step length in 62.5 us units, the write cycle included
  assign step_units = 16'(16'h0001 << rom_delay) + dps_pkg::STEP_BASE_UNITS;
  assign unit_tick = (prescale == PRESCALE_W'(TICK_CYCLES - 1));
  assign step_done = (state == dps_pkg::DPS_WAIT) && unit_tick
    && (unit_count == step_units - 16'h0001);
  assign seq_apply = (state == dps_pkg::DPS_WRITE) && (rom_addr != dps_pkg::ADDR_DUMMY);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= dps_pkg::DPS_IDLE;
      seq_index <= 5'h00;
    end else if (launch) begin
      // A new launch abandons any sequence in progress
      state <= dps_pkg::DPS_WRITE;
      seq_index <= launch_index;
    end else begin
      unique case (state)
        dps_pkg::DPS_IDLE: begin
          state <= dps_pkg::DPS_IDLE;
        end
        dps_pkg::DPS_WRITE: begin
          state <= dps_pkg::DPS_WAIT;
        end
        dps_pkg::DPS_WAIT: begin
          if (step_done && rom_end) begin
            state <= dps_pkg::DPS_IDLE;
          end else if (step_done) begin
            state <= dps_pkg::DPS_WRITE;
            seq_index <= seq_index + 5'h01;
          end
        end
        default: begin
          state <= dps_pkg::DPS_IDLE;
        end
      endcase
    end
  end

  // Cycle divider making the 62.5 us unit enable, aligned to each step
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prescale <= '0;
      unit_count <= 16'h0000;
    end else if (state == dps_pkg::DPS_WRITE) begin
      prescale <= PRESCALE_W'(1);
      unit_count <= 16'h0000;
    end else if (state == dps_pkg::DPS_WAIT && unit_tick) begin
      prescale <= '0;
      unit_count <= unit_count + 16'h0001;
    end else if (state == dps_pkg::DPS_WAIT) begin
      prescale <= prescale + PRESCALE_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seq_cmd <= 16'h0000;
    end else if (launch) begin
      seq_cmd <= reg_wdata;
    end
  end

  assign seq_busy = (state != dps_pkg::DPS_IDLE);

  // ==========================================================
  // Control registers
  // ==========================================================
  logic [15:0] ctl [dps_pkg::NUM_SLOTS];
  logic [15:0] next_ctl [dps_pkg::NUM_SLOTS];

  // Host write lands first; a step in the same cycle overrides its field
  always_comb begin
    for (int i = 0; i < dps_pkg::NUM_SLOTS; i++) begin
      next_ctl[i] = ctl[i];
      if (reg_wr && host_slot[3] && host_slot[2:0] == 3'(i)) begin
        next_ctl[i] = reg_wdata;
      end
      if (seq_apply && seq_slot[3] && seq_slot[2:0] == 3'(i)) begin
        next_ctl[i] = field_merge(next_ctl[i], rom_start, rom_width, rom_data);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < dps_pkg::NUM_SLOTS; i++) begin
      if (reset) begin
        ctl[i] <= dps_pkg::SLOT_RESET[i];
      end else begin
        ctl[i] <= next_ctl[i];
      end
    end
  end

  // ==========================================================
  // Register read
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd && host_slot[3]) begin
      reg_rdata <= ctl[host_slot[2:0]];
    end else if (reg_rd && reg_addr == dps_pkg::ADDR_SEQ_CTRL) begin
      reg_rdata <= seq_busy ? seq_cmd : 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= 16'h0000;
    end
  end

  // ==========================================================
  // Input mid-rail clamps
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      input_pair1_midrail_tie <= 1'b0;
      input_pair2_midrail_tie <= 1'b0;
    end else begin
      input_pair1_midrail_tie <= ctl[dps_pkg::SLOT_IN1][dps_pkg::BIT_CLAMP]
        && !in1_stage_on;
      input_pair2_midrail_tie <= ctl[dps_pkg::SLOT_IN2][dps_pkg::BIT_CLAMP]
        && !in2_stage_on;
    end
  end

  // ==========================================================
  // Control outputs
  // ==========================================================
  assign midrail_buffer_on = ctl[dps_pkg::SLOT_ANTIPOP][dps_pkg::BIT_MIDRAIL_BUF];
  assign charge_pump_on = ctl[dps_pkg::SLOT_CP][dps_pkg::BIT_CHARGE_PUMP];
  assign hp_left_input_stage_on = ctl[dps_pkg::SLOT_PWR][dps_pkg::BIT_HP_LEFT_IN];
  assign hp_right_input_stage_on = ctl[dps_pkg::SLOT_PWR][dps_pkg::BIT_HP_RIGHT_IN];
  assign speaker_driver_on = ctl[dps_pkg::SLOT_PWR][dps_pkg::BIT_SPEAKER_ON];
  assign hp_left_delay_stage = ctl[dps_pkg::SLOT_HP][dps_pkg::BIT_HP_LEFT_DLY];
  assign hp_right_delay_stage = ctl[dps_pkg::SLOT_HP][dps_pkg::BIT_HP_RIGHT_DLY];
  assign hp_left_output_stage = ctl[dps_pkg::SLOT_HP][dps_pkg::BIT_HP_LEFT_OUTP];
  assign hp_right_output_stage = ctl[dps_pkg::SLOT_HP][dps_pkg::BIT_HP_RIGHT_OUTP];
  assign hp_left_unshort = ctl[dps_pkg::SLOT_HP][dps_pkg::BIT_HP_LEFT_UNSHORT];
  assign hp_right_unshort = ctl[dps_pkg::SLOT_HP][dps_pkg::BIT_HP_RIGHT_UNSHORT];
  assign offset_servo_ch0_on = ctl[dps_pkg::SLOT_SERVO][dps_pkg::BIT_SERVO_CH0];
  assign offset_servo_ch1_on = ctl[dps_pkg::SLOT_SERVO][dps_pkg::BIT_SERVO_CH1];
  assign offset_servo_ch0_kick = ctl[dps_pkg::SLOT_SERVO][dps_pkg::BIT_KICK_CH0];
  assign offset_servo_ch1_kick = ctl[dps_pkg::SLOT_SERVO][dps_pkg::BIT_KICK_CH1];

endmodule : dps_sequencer
`default_nettype wire

// File: hw/dps_step_rom.sv
// Factory step table of the write sequencer: one entry per index.
// Purely combinational; the caller holds the index steady per step.
`timescale 1ns/1ps
`default_nettype none

module dps_step_rom (
  input wire logic [4:0] index,
  output logic [7:0] step_addr,
  output logic [2:0] step_field_width,
  output logic [3:0] step_start,
  output logic [7:0] step_data,
  output logic [3:0] step_delay_code,
  output logic step_end_flag
);

  // ==========================================================
  // Table: {addr, width-1, start, data, delay, end}
  // ==========================================================
  logic [27:0] entry;

  always_comb begin
    unique case (index)
      5'h00: entry = {8'h4C, 3'h0, 4'hF, 8'h01, 4'h6, 1'b0};
      5'h01: entry = {8'h01, 3'h2, 4'h7, 8'h07, 4'h0, 1'b0};
      5'h02: entry = {8'h60, 3'h4, 4'h1, 8'h11, 4'h0, 1'b0};
      5'h03: entry = {8'h54, 3'h6, 4'h0, 8'h33, 4'h9, 1'b0};
      5'h04: entry = {8'hFF, 3'h0, 4'h0, 8'h00, 4'h5, 1'b0};
      5'h05: entry = {8'hFF, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0};
      5'h06: entry = {8'hFF, 3'h0, 4'h0, 8'h00, 4'h0, 1'b0};
      5'h07: entry = {8'h60, 3'h5, 4'h2, 8'h3B, 4'h0, 1'b1};
      5'h10: entry = {8'h60, 3'h6, 4'h1, 8'h00, 4'h0, 1'b0};
      5'h11: entry = {8'h54, 3'h1, 4'h0, 8'h00, 4'h0, 1'b0};
      5'h12: entry = {8'h01, 3'h1, 4'h8, 8'h00, 4'h0, 1'b0};
      5'h13: entry = {8'h4C, 3'h0, 4'hF, 8'h00, 4'h0, 1'b0};
      5'h14: entry = {8'h01, 3'h1, 4'hC, 8'h00, 4'h0, 1'b1};
      // Unprogrammed indices stop the sequencer with a harmless write
      default: entry = {8'hFF, 3'h0, 4'h0, 8'h00, 4'h0, 1'b1};
    endcase
  end

  assign step_addr = entry[27:20];
  assign step_field_width = entry[19:17];
  assign step_start = entry[16:13];
  assign step_data = entry[12:5];
  assign step_delay_code = entry[4:1];
  assign step_end_flag = entry[0];

endmodule : dps_step_rom
`default_nettype wire
